//--- rtl/srp_defines.svh
// constants of the shadow register port: bus addresses, register offsets, fields
// assumes nothing; included by both link ends
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH
// ************
// link
// ************
`define SRP_DEV_ADDR    7'h10
`define SRP_CTL_ADDR    7'h11
`define SRP_PASS_PTR    8'h81
`define SRP_PASS_B0     8'hf4
`define SRP_PASS_B1     8'h4f
`define SRP_ACK_SLOT    4'h8
`define SRP_LAST_BIT    4'h7
`define SRP_READ_LOCKED 8'h00
// ************
// shadow registers
// ************
`define SRP_REG_CFG     7'h00
`define SRP_REG_KEY3    7'h01
`define SRP_REG_KEY2    7'h02
`define SRP_REG_KEY1    7'h03
`define SRP_REG_KEY0    7'h04
`define SRP_REG_CXH     7'h09
`define SRP_REG_CXL     7'h0a
`define SRP_REG_CYH     7'h0f
`define SRP_REG_CYL     7'h10
`define SRP_CFG_LOCK    0
`define SRP_CFG_MODE    1
`define SRP_KEY_LEN     4'h4
`define SRP_KEY_LEN_EXT 4'h8
// ************
// host registers
// ************
`define SRP_HR_CMD      4'h0
`define SRP_HR_STAT     4'h4
`define SRP_HR_DIV      4'h8
`define SRP_CMD_START   8
`define SRP_CMD_RD      9
`define SRP_CMD_NACK    10
`define SRP_CMD_STOP    11
`define SRP_STAT_BUSY   8
`define SRP_STAT_NACK   9
`define SRP_DIV_RST     16'h0004
`define SRP_RESP_OKAY   2'b00
`define SRP_RESP_SLVERR 2'b10
`endif

//--- rtl/srp_pkg.sv
// types shared by both ends of the shadow register port
// assumes srp_defines.svh for the numbers
package srp_pkg;
   typedef enum logic [2:0] {
      SRP_D_IDLE  = 3'b000,
      SRP_D_ADDR  = 3'b001,
      SRP_D_PTR   = 3'b010,
      SRP_D_WDATA = 3'b011,
      SRP_D_RDATA = 3'b100
   } srp_dev_st_t;
   typedef enum logic [1:0] {
      SRP_M_IDLE  = 2'b00,
      SRP_M_START = 2'b01,
      SRP_M_BITS  = 2'b10,
      SRP_M_STOP  = 2'b11
   } srp_mst_st_t;
endpackage : srp_pkg

//--- rtl/srp_if.sv
// two-wire link between the host end and the shadow register port
// assumes push-pull clock from the host and open-drain data with a pull-up
`timescale 1ns/10ps
interface srp_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   wire  sda;
   // wired-and with pull-up: any driving end that drives low wins
   assign sda = ((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o)) ? 1'b0 : 1'b1;
   modport host (output scl, output m_sda_o, output m_sda_oe, input sda);
   modport dev  (input scl, output s_sda_o, output s_sda_oe, input sda);
endinterface : srp_if

//--- rtl/srp_sync.sv
// two-stage synchroniser for a pin that comes from outside core_clk
// assumes nothing but the clock and reset
`timescale 1ns/10ps
module srp_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         dout   <= RST_VAL;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : srp_sync

//--- rtl/srp_dev.sv
// shadow register port: two-wire slave over a 128-byte shadow register file
// assumes the otp store answers otp_rdata in the same cycle as otp_addr
// assumes a host that runs the link slower than about ten core_clk per bit
//
// What this block does
// - slave only, answers device address 0x10
// - compare address, ack and prepare direction
// - address byte lsb zero writes, one reads
// - pointer msb selects block, low bits address
// - address 0x10 reaches shadow registers 0x00-0x7f
// - pass code 0x22,0x81,0xf4,0x4f,stop enters mode
// - host single read: pointer write, then 0x21
// - block read continues until host not-acknowledges
// - host single write: address, pointer, one byte
// - block write runs to stop, wraps at 127
// - lock enable bit plus stored key arms lockout
// - key written in ascending order unlocks
// - mode bit appends four coefficients to key
// - wrong key blocks unlocking until reset
// - locked reads return zero
// - locked ignores lock enable and key3-key0 writes; coefficient writes still land
// - locked blocks direct otp access
// - locked still accepts other shadow writes
// - one host, no other slaves on link
// - control mode suspends check, rechecks on leaving
// - reset reloads every shadow register from otp
`timescale 1ns/10ps
module srp_dev
   import srp_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst,
   srp_if.dev        bus,
   output logic [6:0] otp_addr,
   input  wire logic [7:0] otp_rdata,
   output logic      load_busy,
   input  wire logic ctrl_exit,
   output logic      ctrl_mode,
   output logic      crc_check_en,
   output logic      crc_check_req,
   output logic      locked,
   output logic      direct_access_ok
);
`include "srp_defines.svh"
   // ************
   // pin sampling and bus conditions
   // ************
   logic scl_s, sda_s, scl_p_q, sda_p_q;
   srp_sync u_scl (.core_clk(core_clk), .rst(rst), .din(bus.scl), .dout(scl_s));
   srp_sync u_sda (.core_clk(core_clk), .rst(rst), .din(bus.sda), .dout(sda_s));
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end
   wire start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
   wire stop_c  = scl_s && scl_p_q && !sda_p_q && sda_s;
   wire rise_c  = scl_s && !scl_p_q;
   wire fall_c  = !scl_s && scl_p_q;

   // ************
   // state
   // ************
   logic [7:0]  mem [0:127];
   srp_dev_st_t st_q;
   logic [3:0]  cnt_q, key_idx_q;
   logic [7:0]  sh_q, tx_q, load_idx_q;
   logic [6:0]  addr_q;
   logic [1:0]  pass_q;
   logic        ack_q, oe_q, burst_q, first_q, ctl_q;
   logic        mode_q, chk_q, unlocked_q, fail_q;

   // ************
   // decode
   // ************
   wire [7:0] byte_in   = {sh_q[6:0], sda_s};
   wire       loading   = !load_idx_q[7];
   wire [7:0] cfg       = mem[`SRP_REG_CFG];
   wire       ext       = cfg[`SRP_CFG_MODE];
   wire       lock_c    = cfg[`SRP_CFG_LOCK] && !unlocked_q && !loading;
   wire       dev_hit   = (byte_in[7:1] == `SRP_DEV_ADDR) && !loading;
   wire       ctl_hit   = (byte_in[7:1] == `SRP_CTL_ADDR) && !byte_in[0];
   wire [6:0] nxt_addr  = burst_q ? addr_q + 7'h01 : addr_q;
   wire [7:0] rd_now    = lock_c ? `SRP_READ_LOCKED : mem[addr_q];
   wire [7:0] rd_nxt    = lock_c ? `SRP_READ_LOCKED : mem[nxt_addr];
   wire       is_key    = (addr_q >= `SRP_REG_KEY3) && (addr_q <= `SRP_REG_KEY0);
   wire       is_coef   = (addr_q == `SRP_REG_CXH) || (addr_q == `SRP_REG_CXL)
                          || (addr_q == `SRP_REG_CYH) || (addr_q == `SRP_REG_CYL);
   wire       key_part  = is_key || (ext && is_coef);
   wire [3:0] key_len   = ext ? `SRP_KEY_LEN_EXT : `SRP_KEY_LEN;
   logic [6:0] key_exp;
   always_comb begin
      case (key_idx_q[2:0])
         3'd0:    key_exp = `SRP_REG_KEY3;
         3'd1:    key_exp = `SRP_REG_KEY2;
         3'd2:    key_exp = `SRP_REG_KEY1;
         3'd3:    key_exp = `SRP_REG_KEY0;
         3'd4:    key_exp = `SRP_REG_CXH;
         3'd5:    key_exp = `SRP_REG_CXL;
         3'd6:    key_exp = `SRP_REG_CYH;
         default: key_exp = `SRP_REG_CYL;
      endcase
   end
   wire ack_slot = rise_c && (cnt_q == `SRP_ACK_SLOT);
   wire byte_wr  = ack_slot && (st_q == SRP_D_WDATA) && ack_q && !ctl_q;
   // lock enable and key bytes are kept while locked; the key byte writes feed the key check instead
   wire wr_block = lock_c && (is_key || addr_q == `SRP_REG_CFG);
   wire key_try  = byte_wr && lock_c && key_part && !fail_q;
   wire key_good = (addr_q == key_exp) && (sh_q == mem[addr_q]);
   logic ack_want;
   always_comb begin
      case (st_q)
         SRP_D_ADDR:  ack_want = dev_hit || ctl_hit;
         SRP_D_PTR:   ack_want = 1'b1;
         SRP_D_WDATA: ack_want = ctl_q || burst_q || first_q;
         default:     ack_want = 1'b0;
      endcase
   end

   // ************
   // shadow file: otp upload after reset, then link writes
   // ************
   always_ff @(posedge core_clk) begin
      if (loading) begin
         mem[load_idx_q[6:0]] <= otp_rdata;
      end else if (byte_wr && !wr_block) begin
         mem[addr_q] <= sh_q;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         load_idx_q <= 8'h00;
      end else if (loading) begin
         load_idx_q <= load_idx_q + 8'h01;
      end
   end

   // ************
   // link byte engine
   // ************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q    <= SRP_D_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         tx_q    <= 8'h00;
         addr_q  <= 7'h00;
         ack_q   <= 1'b0;
         oe_q    <= 1'b0;
         burst_q <= 1'b0;
         first_q <= 1'b0;
         ctl_q   <= 1'b0;
         pass_q  <= 2'd0;
      end else if (start_c) begin
         st_q  <= SRP_D_ADDR;
         cnt_q <= 4'h0;
         oe_q  <= 1'b0;
      end else if (stop_c) begin
         st_q <= SRP_D_IDLE;
         oe_q <= 1'b0;
      end else if (st_q == SRP_D_IDLE) begin
         oe_q <= 1'b0;
      end else if (rise_c && cnt_q != `SRP_ACK_SLOT) begin
         sh_q  <= byte_in;
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == `SRP_LAST_BIT) begin
            ack_q <= ack_want;
         end
      end else if (ack_slot) begin
         cnt_q <= 4'h0;
         case (st_q)
            SRP_D_ADDR: begin
               ctl_q <= (sh_q[7:1] == `SRP_CTL_ADDR);
               if (!ack_q) begin
                  st_q <= SRP_D_IDLE;
               end else if (sh_q[0]) begin
                  st_q <= SRP_D_RDATA;
                  tx_q <= rd_now;
               end else begin
                  st_q <= SRP_D_PTR;
               end
            end
            SRP_D_PTR: begin
               addr_q  <= sh_q[6:0];
               burst_q <= sh_q[7];
               first_q <= 1'b1;
               pass_q  <= (sh_q == `SRP_PASS_PTR) ? 2'd1 : 2'd0;
               st_q    <= SRP_D_WDATA;
            end
            SRP_D_WDATA: begin
               if (!ack_q) begin
                  st_q <= SRP_D_IDLE;
               end else if (ctl_q) begin
                  if (pass_q == 2'd1 && sh_q == `SRP_PASS_B0) begin
                     pass_q <= 2'd2;
                  end else if (pass_q == 2'd2 && sh_q == `SRP_PASS_B1) begin
                     pass_q <= 2'd3;
                  end else begin
                     pass_q <= 2'd0;
                  end
               end else begin
                  first_q <= 1'b0;
                  addr_q  <= nxt_addr;
               end
            end
            default: begin
               if (!sda_s) begin
                  addr_q <= nxt_addr;
                  tx_q   <= rd_nxt;
               end else begin
                  st_q <= SRP_D_IDLE;
               end
            end
         endcase
      end else if (fall_c) begin
         // data changes only while the clock is low, so it never mimics start or stop
         if (st_q == SRP_D_RDATA && cnt_q != `SRP_ACK_SLOT) begin
            oe_q <= !tx_q[3'd7 - cnt_q[2:0]];
         end else begin
            oe_q <= (cnt_q == `SRP_ACK_SLOT) && ack_q;
         end
      end
   end

   // ************
   // lockout and control mode
   // ************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         key_idx_q  <= 4'h0;
         unlocked_q <= 1'b0;
         fail_q     <= 1'b0;
         mode_q     <= 1'b0;
         chk_q      <= 1'b0;
      end else begin
         if (key_try && key_good) begin
            key_idx_q <= key_idx_q + 4'h1;
            if (key_idx_q + 4'h1 == key_len) begin
               unlocked_q <= 1'b1;
            end
         end else if (key_try) begin
            fail_q <= 1'b1;
         end
         chk_q <= mode_q && ctrl_exit;
         if (stop_c && st_q != SRP_D_IDLE && ctl_q && pass_q == 2'd3) begin
            mode_q <= 1'b1;
         end else if (ctrl_exit) begin
            mode_q <= 1'b0;
         end
      end
   end

   // ************
   // outputs
   // ************
   assign bus.s_sda_o      = 1'b0;
   assign bus.s_sda_oe     = oe_q;
   assign otp_addr         = load_idx_q[6:0];
   assign load_busy        = loading;
   assign ctrl_mode        = mode_q;
   assign crc_check_en     = !mode_q;
   assign crc_check_req    = chk_q;
   assign locked           = lock_c;
   assign direct_access_ok = !lock_c;
endmodule : srp_dev

//--- rtl/srp_host.sv
// host end: byte-level two-wire master driven from an axi4-lite register slave
// assumes a single slave on the link and software that polls the busy bit
`timescale 1ns/10ps
module srp_host
   import srp_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   srp_if.host              bus
);
`include "srp_defines.svh"
   // ************
   // register slave
   // ************
   logic        aw_q, w_q, bv_q, rv_q;
   logic [3:0]  awa_q;
   logic [31:0] wd_q, rd_q;
   logic [1:0]  br_q, rr_q;
   logic [15:0] div_q, dcnt_q;
   logic [7:0]  tx_q, rx_q;
   logic        rd_q_f, nk_q, stop_q, nack_q;
   srp_mst_st_t st_q;
   logic [1:0]  ph_q;
   logic [3:0]  bit_q;
   logic        scl_q, sda_q;
   logic        sda_s;
   srp_sync u_sda (.core_clk(core_clk), .rst(rst), .din(bus.sda), .dout(sda_s));

   wire do_wr   = aw_q && w_q && !bv_q;
   wire busy    = (st_q != SRP_M_IDLE);
   wire hit_cmd = (awa_q == `SRP_HR_CMD);
   wire hit_div = (awa_q == `SRP_HR_DIV);
   wire hit_wok = hit_cmd || hit_div || (awa_q == `SRP_HR_STAT);
   wire go      = do_wr && hit_cmd && !busy;
   wire [31:0] stat_w = {22'h00_0000, nack_q, busy, rx_q};
   wire [31:0] rsel   = (s_axi_araddr == `SRP_HR_STAT) ? stat_w
                      : (s_axi_araddr == `SRP_HR_DIV)  ? {16'h0000, div_q} : 32'h0000_0000;
   wire        rok    = (s_axi_araddr == `SRP_HR_STAT) || (s_axi_araddr == `SRP_HR_DIV)
                        || (s_axi_araddr == `SRP_HR_CMD);
   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready  = !w_q && !bv_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         bv_q  <= 1'b0;
         awa_q <= 4'h0;
         wd_q  <= 32'h0000_0000;
         br_q  <= `SRP_RESP_OKAY;
         div_q <= `SRP_DIV_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q  <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q  <= 1'b1;
            wd_q <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            bv_q <= 1'b1;
            br_q <= hit_wok ? `SRP_RESP_OKAY : `SRP_RESP_SLVERR;
            // a zero divider would wrap the count to 65536 core_clk per phase, so it reads back as one
            if (hit_div && s_axi_wstrb[0] && s_axi_wstrb[1]) begin
               div_q <= (wd_q[15:0] == 16'h0000) ? 16'h0001 : wd_q[15:0];
            end
         end else if (bv_q && s_axi_bready) begin
            bv_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= `SRP_RESP_OKAY;
      end else if (s_axi_arvalid && !rv_q) begin
         rv_q <= 1'b1;
         rd_q <= rsel;
         rr_q <= rok ? `SRP_RESP_OKAY : `SRP_RESP_SLVERR;
      end else if (rv_q && s_axi_rready) begin
         rv_q <= 1'b0;
      end
   end

   // ************
   // link sequencer: four phases per bit, one tick per phase
   // ************
   wire tick = (dcnt_q == 16'h0000);
   wire last_bit = (bit_q == `SRP_ACK_SLOT);
   wire bit_val  = last_bit ? (!rd_q_f || nk_q)
                            : (rd_q_f || tx_q[3'd7 - bit_q[2:0]]);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dcnt_q <= 16'h0000;
      end else if (go || tick) begin
         dcnt_q <= div_q - 16'h0001;
      end else begin
         dcnt_q <= dcnt_q - 16'h0001;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q   <= SRP_M_IDLE;
         ph_q   <= 2'd0;
         bit_q  <= 4'h0;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         tx_q   <= 8'h00;
         rx_q   <= 8'h00;
         rd_q_f <= 1'b0;
         nk_q   <= 1'b0;
         stop_q <= 1'b0;
         nack_q <= 1'b0;
      end else if (go) begin
         tx_q   <= wd_q[7:0];
         rd_q_f <= wd_q[`SRP_CMD_RD];
         nk_q   <= wd_q[`SRP_CMD_NACK];
         stop_q <= wd_q[`SRP_CMD_STOP];
         st_q   <= wd_q[`SRP_CMD_START] ? SRP_M_START : SRP_M_BITS;
         ph_q   <= 2'd0;
         bit_q  <= 4'h0;
      end else if (tick && busy) begin
         ph_q <= ph_q + 2'd1;
         case (st_q)
            SRP_M_START: begin
               if (ph_q == 2'd0) sda_q <= 1'b1;
               if (ph_q == 2'd1) scl_q <= 1'b1;
               if (ph_q == 2'd2) sda_q <= 1'b0;
               if (ph_q == 2'd3) begin
                  scl_q <= 1'b0;
                  st_q  <= SRP_M_BITS;
               end
            end
            SRP_M_BITS: begin
               if (ph_q == 2'd0) sda_q <= bit_val;
               if (ph_q == 2'd1) scl_q <= 1'b1;
               if (ph_q == 2'd2 && !last_bit && rd_q_f) rx_q <= {rx_q[6:0], sda_s};
               if (ph_q == 2'd2 && last_bit && !rd_q_f) nack_q <= sda_s;
               if (ph_q == 2'd3) begin
                  scl_q <= 1'b0;
                  bit_q <= bit_q + 4'h1;
                  if (last_bit) st_q <= stop_q ? SRP_M_STOP : SRP_M_IDLE;
               end
            end
            default: begin
               if (ph_q == 2'd0) sda_q <= 1'b0;
               if (ph_q == 2'd1) scl_q <= 1'b1;
               if (ph_q == 2'd2) sda_q <= 1'b1;
               if (ph_q == 2'd3) st_q <= SRP_M_IDLE;
            end
         endcase
      end
   end
   assign bus.scl      = scl_q;
   assign bus.m_sda_o  = 1'b0;
   assign bus.m_sda_oe = !sda_q;
endmodule : srp_host

//--- verif/srp_link_properties.sv
// checker: properties of the two-wire link between host end and device end
// assumes scl and sda are launched from core_clk flops, so core_clk sees every edge
`timescale 1ns/10ps
module srp_link_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic sda
);
   // ************
   // frame tracker
   // ************
   logic       scl_q, sda_q, first_q, ign_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   wire        start = scl && scl_q && sda_q && !sda;
   wire        rise  = scl && !scl_q;
   wire        slot  = rise && cnt_q == 4'h8 && first_q;
   // pass code address is acked too; reads of it are not
   wire        miss  = sh_q[7:1] != 7'h10 && sh_q != 8'h22;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {scl_q, sda_q} <= 2'b11;
         {first_q, ign_q, cnt_q, sh_q} <= '0;
      end else begin
         {scl_q, sda_q} <= {scl, sda};
         if (start) begin
            {first_q, ign_q, cnt_q} <= {2'b10, 4'h0};
         end else if (rise && cnt_q == 4'h8) begin
            {cnt_q, first_q, ign_q} <= {4'h0, 1'b0, ign_q | (first_q && miss)};
         end else if (rise) begin
            {cnt_q, sh_q} <= {cnt_q + 4'h1, sh_q[6:0], sda};
         end
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   chk_wired_and_sda: assert property (sda == !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o)))
      else $error("sda level does not match the drivers");
   chk_dev_drive_low: assert property (s_sda_oe |-> !s_sda_o)
      else $error("device drives sda high");
   chk_host_drive_low: assert property (m_sda_oe |-> !m_sda_o)
      else $error("host drives sda high");
   chk_dev_steady_high: assert property (scl && scl_q |-> $stable(s_sda_oe))
      else $error("device changed sda while scl high");
   chk_addr_acked: assert property (slot && !miss |-> !sda)
      else $error("own address not acknowledged");
   chk_addr_not_acked: assert property (slot && miss |-> sda)
      else $error("foreign address acknowledged");
   chk_foreign_quiet: assert property (ign_q |-> !s_sda_oe)
      else $error("device drove sda during a foreign frame");
   chk_start_released: assert property (start |-> !s_sda_oe ##1 !s_sda_oe)
      else $error("device held sda across a start");
   cover property (slot && !miss);
   cover property (slot && miss);
   cover property (ign_q && start);
endmodule : srp_link_properties

//--- verif/shadow_register_i2c_port_tb.sv
// testbench: host end and device end joined by srp_if, driven over axi4-lite
// assumes the otp store model below answers in the same cycle
`timescale 1ns/10ps
`include "srp_defines.svh"
module shadow_register_i2c_port_tb;
   // ************
   // harness
   // ************
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic        ctrl_exit = 1'b0;
   logic [3:0]  awa = 4'h0, ara = 4'h0, wstrb = 4'hf;
   logic [31:0] wd = 32'h0000_0000, st, rdata;
   logic [7:0]  n_req = 8'h00, otp_rdata;
   logic [7:0]  q[$];
   logic [1:0]  rsp, bresp, rresp;
   logic [6:0]  otp_addr;
   logic        awr, wr, bv, arr, rv, load_busy, ctrl_mode, crc_en, crc_req, locked, dok;
   int          n_mismatch = 0, checks = 0;
   srp_if bus ();
   srp_host u_srp_host (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
      .bus(bus.host));
   srp_dev u_srp_dev (.core_clk(core_clk), .rst(rst), .bus(bus.dev), .otp_addr(otp_addr),
      .otp_rdata(otp_rdata), .load_busy(load_busy), .ctrl_exit(ctrl_exit),
      .ctrl_mode(ctrl_mode), .crc_check_en(crc_en), .crc_check_req(crc_req),
      .locked(locked), .direct_access_ok(dok));
   srp_link_properties u_srp_link_properties (.core_clk(core_clk), .rst(rst),
      .scl(bus.scl), .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
      .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .sda(bus.sda));
   // otp content is a plain pattern; byte 0 keeps the lock bit clear at reset
   function automatic logic [7:0] ov(input logic [6:0] a);
      return (a == 7'h00) ? 8'h00 : {1'b0, a} ^ 8'h30;
   endfunction : ov
   assign otp_rdata = ov(otp_addr);
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) if (crc_req === 1'b1) n_req <= n_req + 8'h01;
   task results;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task cmp8(input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask : cmp8
   task cmp1(input logic e, input logic g);
      cmp8({7'h00, e}, {7'h00, g});
   endtask : cmp1
   // ************
   // access tasks
   // ************
   task rst_cycle;
      rst <= 1'b1;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      wait (load_busy === 1'b0);
      @(posedge core_clk);
   endtask : rst_cycle
   // the leading edge keeps back-to-back calls from driving a signal twice at once
   task axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {awa, wd, awv, wv, brdy} <= {a, d, 3'b111};
      do begin
         @(posedge core_clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (bv !== 1'b1);
      rsp = bresp;
      brdy <= 1'b0;
   endtask : axw
   task axr(input logic [3:0] a);
      @(posedge core_clk);
      {ara, arv, rrdy} <= {a, 2'b11};
      do begin
         @(posedge core_clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      {st, rsp} = {rdata, rresp};
      rrdy <= 1'b0;
   endtask : axr
   task cmd(input logic [11:0] c);
      axw(`SRP_HR_CMD, {20'h0_0000, c});
      do axr(`SRP_HR_STAT); while (st[8] !== 1'b0);
   endtask : cmd
   task sw(input logic [6:0] a, input logic [7:0] d);
      cmd(12'h120);
      cmd({5'h00, a});
      cmd({4'h8, d});
   endtask : sw
   task sr(input logic [6:0] a, input logic [7:0] e);
      cmd(12'h120);
      cmd({5'h00, a});
      cmd(12'h121);
      cmd(12'he00);
      cmp8(e, st[7:0]);
   endtask : sr
   task bw(input logic [7:0] sa, input logic [6:0] a);
      cmd({4'h1, sa});
      cmd({5'h01, a});
      foreach (q[i]) cmd({(i == q.size() - 1) ? 4'h8 : 4'h0, q[i]});
   endtask : bw
   task br(input logic [6:0] a);
      cmd(12'h120);
      cmd({5'h01, a});
      cmd(12'h121);
      foreach (q[i]) begin
         cmd((i == q.size() - 1) ? 12'he00 : 12'h200);
         cmp8(q[i], st[7:0]);
      end
   endtask : br
   // ************
   // tests
   // ************
   initial begin
      repeat (90000) @(posedge core_clk);
      n_mismatch++;
      results();
   end
   initial begin
      logic [7:0] pa [3];
      logic [6:0] ca [4];
      pa = '{8'h20, 8'h30, 8'h23};
      ca = '{7'h09, 7'h0a, 7'h0f, 7'h10};
      rst_cycle();
      axr(4'hc);
      cmp8({6'h00, `SRP_RESP_SLVERR}, {6'h00, rsp});
      axw(4'hc, 32'h0000_0000);
      cmp8({6'h00, `SRP_RESP_SLVERR}, {6'h00, rsp});
      foreach (pa[i]) begin
         cmd({4'h1, pa[i]});
         cmp1(i != 0, st[9]);
         cmd(12'h8ff);
      end
      sr(7'h07, ov(7'h07));
      sw(7'h05, 8'haa);
      sr(7'h05, 8'haa);
      q = '{8'ha1, 8'ha2, 8'h00};
      bw(8'h20, 7'h7e);
      br(7'h7e);
      q = '{8'hf4, 8'h4f};
      bw(8'h22, 7'h01);
      cmp1(1'b1, ctrl_mode);
      cmp1(1'b0, crc_en);
      ctrl_exit <= 1'b1;
      @(posedge core_clk);
      ctrl_exit <= 1'b0;
      repeat (3) @(posedge core_clk);
      cmp8(8'h01, n_req);
      cmp1(1'b1, crc_en);
      sw(7'h00, 8'h01);
      cmp1(1'b1, locked);
      cmp1(1'b0, dok);
      sr(7'h07, 8'h00);
      sw(7'h00, 8'h00);
      cmp1(1'b1, locked);
      sw(7'h05, 8'h5c);
      q = '{8'h31, 8'h32, 8'h33, 8'h34};
      bw(8'h20, 7'h01);
      cmp1(1'b0, locked);
      sr(7'h05, 8'h5c);
      // a good key stays accepted until reset, so relocking needs a fresh start
      rst_cycle();
      sw(7'h00, 8'h03);
      bw(8'h20, 7'h01);
      cmp1(1'b1, locked);
      foreach (ca[i]) sw(ca[i], ov(ca[i]));
      cmp1(1'b0, locked);
      rst_cycle();
      sw(7'h00, 8'h01);
      sw(7'h01, 8'h77);
      bw(8'h20, 7'h01);
      cmp1(1'b1, locked);
      sr(7'h01, 8'h00);
      rst_cycle();
      sr(7'h7e, ov(7'h7e));
      sw(7'h00, 8'h01);
      bw(8'h20, 7'h01);
      cmp1(1'b0, locked);
      results();
   end
endmodule : shadow_register_i2c_port_tb
